// file: hdl/stc_pkg.sv
// Constants and carrier types for the script transfer control unit.
// Assumes a fetch unit that presents a decoded two-dword instruction.
package stc_pkg;
	// ----------------------------------------------------------------
	// Instruction fields
	// ----------------------------------------------------------------
	localparam int OPC_HI = 29;
	localparam int OPC_LO = 27;
	localparam int PHASE_HI = 26;
	localparam int PHASE_LO = 24;
	localparam int REL_BIT = 23;
	localparam int CARRY_BIT = 21;
	localparam int FLY_BIT = 20;
	localparam int TRUE_BIT = 19;
	localparam int DATA_BIT = 18;
	localparam int PHCMP_BIT = 17;
	localparam int WAIT_BIT = 16;
	localparam int MASK_HI = 15;
	localparam int MASK_LO = 8;
	localparam int VAL_HI = 7;
	localparam int VAL_LO = 0;
	localparam int OFS_W = 24;
	localparam int FLY_STAT_BIT = 2;
	localparam logic [31:0] PTR_RESET = 32'h0000_0000;
	localparam logic [7:0] STAT_RESET = 8'h00;

	typedef enum logic [2:0] {
		STC_OP_JUMP = 3'b000,
		STC_OP_CALL = 3'b001,
		STC_OP_RET = 3'b010,
		STC_OP_INT = 3'b011
	} stc_op_t;

	typedef enum logic [2:0] {
		STC_PH_DOUT = 3'b000,
		STC_PH_DIN = 3'b001,
		STC_PH_CMD = 3'b010,
		STC_PH_STAT = 3'b011,
		STC_PH_RSVO = 3'b100,
		STC_PH_RSVI = 3'b101,
		STC_PH_MSGO = 3'b110,
		STC_PH_MSGI = 3'b111
	} stc_phase_t;

	typedef enum logic [1:0] {
		STC_RUN = 2'b00,
		STC_WAIT = 2'b01,
		STC_HALT = 2'b10
	} stc_state_t;

	typedef struct packed {
		logic msg;
		logic cd;
		logic io;
	} stc_buslines_t;

	typedef struct packed {
		logic [31:0] cmdWord;
		logic [31:0] operand;
	} stc_instr_t;
endpackage : stc_pkg

// file: hdl/stc_unit.sv
// Transfer control unit: decodes jump, call, return and interrupt.
// Assumes the fetch unit holds instrValid until instrDone pulses and
// already advanced the instruction pointer past the current instruction.
`timescale 1ns/1ps
`default_nettype none

module stc_unit
	import stc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic clkEn,
	input wire logic instrValid,
	input wire stc_instr_t instr,
	input wire logic [31:0] nextPtr,
	input wire logic aluCarry,
	input wire logic [7:0] firstByte,
	input wire logic targetMode,
	input wire stc_buslines_t busLinesPin,
	input wire logic busReqPin,
	input wire logic busAtnPin,
	input wire logic hostPtrWrite,
	input wire logic [31:0] hostPtrData,
	input wire logic hostIntAck,
	output logic instrDone_ff,
	output logic [31:0] instrPtr_ff,
	output logic [31:0] retAddr_ff,
	output logic [31:0] operandReg_ff,
	output logic [7:0] intStatus_ff,
	output logic irqReq_n_ff,
	output logic illegalInt_ff,
	output logic halted_ff
);
	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [4:0] syncA_ff;
	logic [4:0] syncB_ff;
	logic reqPrev_ff;
	stc_buslines_t latchedPhase_ff;
	logic phaseNew_ff;
	stc_state_t state_ff;

	// Lines and request share one synchroniser, so the latched phase and
	// its strobe are delayed alike and never seen out of step.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			syncA_ff <= 5'h00;
			syncB_ff <= 5'h00;
		end else if (clkEn) begin
			syncA_ff <= {busLinesPin, busReqPin, busAtnPin};
			syncB_ff <= syncA_ff;
		end
	end

	wire stc_buslines_t linesS = syncB_ff[4:2];
	wire logic reqS = syncB_ff[1];
	wire logic atnS = syncB_ff[0];

	// ----------------------------------------------------------------
	// Phase latch
	// ----------------------------------------------------------------
	// The lines are captured on the request edge, so a compare sees the
	// phase that was announced, not lines that may be mid-change.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			reqPrev_ff <= 1'b0;
			latchedPhase_ff <= '0;
		end else if (clkEn) begin
			reqPrev_ff <= reqS;
			if (reqS && !reqPrev_ff) begin
				latchedPhase_ff <= linesS;
			end
		end
	end

	// ----------------------------------------------------------------
	// Decode and condition
	// ----------------------------------------------------------------
	wire logic [31:0] cw = instr.cmdWord;
	wire logic [2:0] opc = cw[OPC_HI:OPC_LO];
	wire logic opReserved = opc[2];
	wire logic useCarry = cw[CARRY_BIT];
	wire logic usePhase = cw[PHCMP_BIT];
	wire logic useData = cw[DATA_BIT];
	wire logic waitPhase = cw[WAIT_BIT];
	wire logic [7:0] cmpMask = cw[MASK_HI:MASK_LO];
	wire logic [7:0] cmpVal = cw[VAL_HI:VAL_LO];
	wire stc_phase_t wantPhase = stc_phase_t'(cw[PHASE_HI:PHASE_LO]);

	// Target role tests attention instead of the phase field.
	wire logic phaseMatch = targetMode ? atnS : (latchedPhase_ff == wantPhase);

	// ----------------------------------------------------------------
	// Masked byte compare
	// ----------------------------------------------------------------
	// A set mask bit forces its lane to agree, so the writer may leave
	// any value in the matching compare bit.
	wire logic [7:0] laneOk;
	for (genvar i = 0; i < 8; i++) begin : g_lane
		assign laneOk[i] = cmpMask[i] || (firstByte[i] == cmpVal[i]);
	end
	wire logic dataMatch = &laneOk;

	logic condTrue;
	logic condFalse;
	always_comb begin
		condTrue = 1'b1;
		condFalse = 1'b1;
		if (useCarry) begin
			condTrue = aluCarry;
			condFalse = !aluCarry;
		end else if (usePhase && useData) begin
			condTrue = phaseMatch && dataMatch;
			condFalse = !phaseMatch && !dataMatch;
		end else if (usePhase) begin
			condTrue = phaseMatch;
			condFalse = !phaseMatch;
		end else if (useData) begin
			condTrue = dataMatch;
			condFalse = !dataMatch;
		end
	end

	// Unconditional form: no test selected, so branch polarity bit decides
	// nothing and the transfer is always taken.
	wire logic noTest = !useCarry && !usePhase && !useData;
	wire logic taken = noTest || (cw[TRUE_BIT] ? condTrue : condFalse);
	wire logic needWait = waitPhase && (usePhase || useData) && !phaseNew_ff;

	// The sum wraps at the pointer width; a far target needs the absolute form.
	wire logic [31:0] relTarget = nextPtr + {{(32 - OFS_W){instr.operand[OFS_W - 1]}},
		instr.operand[OFS_W - 1:0]};
	wire logic useRel = cw[REL_BIT] && (opc == STC_OP_JUMP || opc == STC_OP_CALL);
	wire logic [31:0] target = useRel ? relTarget : instr.operand;

	// The done flag blocks a second execution in the done cycle, while the
	// fetch unit may still hold instrValid high.
	wire logic execNow = clkEn && instrValid && !instrDone_ff && state_ff != STC_HALT && !needWait;
	// A halting outcome counts in the wait state too, so an interrupt
	// released by a fresh phase still stops the engine.
	wire logic haltNow = execNow && (opReserved || (opc == STC_OP_INT && taken && !cw[FLY_BIT]));

	// ----------------------------------------------------------------
	// Execution state
	// ----------------------------------------------------------------
	stc_state_t nxt_state;
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			STC_RUN: begin
				if (instrValid && !instrDone_ff && needWait) begin
					nxt_state = STC_WAIT;
				end
				if (haltNow) begin
					nxt_state = STC_HALT;
				end
			end
			STC_WAIT: begin
				if (!needWait) begin
					nxt_state = STC_RUN;
				end
				if (haltNow) begin
					nxt_state = STC_HALT;
				end
			end
			STC_HALT: begin
				if (hostPtrWrite) begin
					nxt_state = STC_RUN;
				end
			end
			default: nxt_state = STC_RUN;
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_ff <= STC_RUN;
			halted_ff <= 1'b0;
		end else if (clkEn) begin
			state_ff <= nxt_state;
			halted_ff <= (nxt_state == STC_HALT);
		end
	end

	// A new request edge marks a fresh phase; executing any compare with
	// the wait option consumes it, so the next wait blocks until another.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			phaseNew_ff <= 1'b0;
		end else if (clkEn) begin
			if (reqS && !reqPrev_ff) begin
				phaseNew_ff <= 1'b1;
			end else if (execNow && waitPhase) begin
				phaseNew_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			instrDone_ff <= 1'b0;
		end else if (clkEn) begin
			instrDone_ff <= execNow;
		end
	end

	// ----------------------------------------------------------------
	// Pointer, return address and operand
	// ----------------------------------------------------------------
	// A host write outranks execution, so a halted engine always restarts
	// at the written address.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			instrPtr_ff <= PTR_RESET;
		end else if (clkEn) begin
			if (hostPtrWrite) begin
				instrPtr_ff <= hostPtrData;
			end else if (execNow && !opReserved) begin
				instrPtr_ff <= nextPtr;
				if (taken) begin
					case (stc_op_t'(opc))
						STC_OP_JUMP: instrPtr_ff <= target;
						STC_OP_CALL: instrPtr_ff <= target;
						STC_OP_RET: instrPtr_ff <= retAddr_ff;
						default: instrPtr_ff <= nextPtr;
					endcase
				end
			end
		end
	end

	// Single entry: a nested call simply overwrites the saved address.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			retAddr_ff <= PTR_RESET;
		end else if (clkEn && execNow && opc == STC_OP_CALL && taken) begin
			retAddr_ff <= nextPtr;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			operandReg_ff <= PTR_RESET;
		end else if (clkEn && execNow) begin
			operandReg_ff <= instr.operand;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt outputs
	// ----------------------------------------------------------------
	// Set wins over acknowledge in the same cycle.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			intStatus_ff <= STAT_RESET;
			irqReq_n_ff <= 1'b1;
			illegalInt_ff <= 1'b0;
		end else if (clkEn) begin
			if (hostIntAck) begin
				intStatus_ff[FLY_STAT_BIT] <= 1'b0;
				irqReq_n_ff <= 1'b1;
				illegalInt_ff <= 1'b0;
			end
			if (execNow && opReserved) begin
				illegalInt_ff <= 1'b1;
				irqReq_n_ff <= 1'b0;
			end
			if (execNow && !opReserved && opc == STC_OP_INT && taken) begin
				if (cw[FLY_BIT]) begin
					intStatus_ff[FLY_STAT_BIT] <= 1'b1;
				end else begin
					irqReq_n_ff <= 1'b0;
				end
			end
		end
	end
endmodule : stc_unit

`default_nettype wire

// file: tb/stc_assertions.sv
// Port checker for the transfer control unit.
// Bound onto stc_unit; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module stc_assertions
	import stc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic clkEn,
	input wire logic hostPtrWrite,
	input wire logic [31:0] hostPtrData,
	input wire logic instrDone_ff,
	input wire logic [31:0] instrPtr_ff,
	input wire logic [31:0] retAddr_ff,
	input wire logic [7:0] intStatus_ff,
	input wire logic irqReq_n_ff,
	input wire logic illegalInt_ff,
	input wire logic halted_ff
);
	default clocking dc @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	a_done_pulse: assert property (instrDone_ff && clkEn |=> !instrDone_ff) else $error("done");
	a_halt_stops: assert property (halted_ff |=> !instrDone_ff) else $error("ran");
	a_ptr_cause: assert property ($changed(instrPtr_ff) |-> instrDone_ff || $past(hostPtrWrite)) else $error("ptr");
	a_host_load: assert property (hostPtrWrite && clkEn |=> instrPtr_ff == $past(hostPtrData)) else $error("load");
	a_ret_cause: assert property ($changed(retAddr_ff) |-> instrDone_ff) else $error("ret");
	a_irq_halts: assert property ($fell(irqReq_n_ff) |-> halted_ff) else $error("irq");
	a_bad_halts: assert property ($rose(illegalInt_ff) |-> halted_ff && !irqReq_n_ff && $stable(instrPtr_ff))
		else $error("ill");
	a_fly_runs: assert property ($rose(intStatus_ff[FLY_STAT_BIT]) |-> !halted_ff) else $error("fly");
	c_halt: cover property ($rose(halted_ff));
	c_fly: cover property ($rose(intStatus_ff[FLY_STAT_BIT]));
	c_call: cover property ($changed(retAddr_ff));
endmodule : stc_assertions
bind stc_unit stc_assertions u_chk (.clk_sys, .rst, .clkEn, .hostPtrWrite, .hostPtrData, .instrDone_ff,
	.instrPtr_ff, .retAddr_ff, .intStatus_ff, .irqReq_n_ff, .illegalInt_ff, .halted_ff);
`default_nettype wire

// file: tb/stc_bus_model.sv
// Bus phase model: sets the phase lines, then a request pulse.
// Assumes the bench pulses go with phSel held.
`timescale 1ns/1ps
`default_nettype none
module stc_bus_model
	import stc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic go,
	input wire logic [2:0] phSel,
	output var stc_buslines_t busLinesPin,
	output logic busReqPin
);
	logic [2:0] cnt_ff;
	// Lines settle two cycles before the request rises.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			busLinesPin <= 3'h0;
			cnt_ff <= 3'h0;
			busReqPin <= 1'b0;
		end else begin
			if (go) begin
				busLinesPin <= phSel;
				cnt_ff <= 3'h1;
			end else if (cnt_ff != 3'h0) begin
				cnt_ff <= cnt_ff + 3'h1;
			end
			busReqPin <= cnt_ff[2] | cnt_ff[1];
		end
	end
endmodule : stc_bus_model
`default_nettype wire

// file: tb/tb_script_transfer_control_unit.sv
// Bench for the transfer control unit.
// Assumes stc_bus_model stands in for the bus phase logic.
`timescale 1ns/1ps
`default_nettype none
`define CK(a, e) begin checksDone++; if ((a) !== (e)) begin nFail++; $display("ERROR %0t %h %h", $time, a, e); end end
module tb_script_transfer_control_unit;
	import stc_pkg::*;
	logic clk_sys = 1'b0, rst = 1'b1, instrValid = 1'b0, aluCarry = 1'b0, targetMode = 1'b0, busAtnPin = 1'b0;
	logic hostPtrWrite = 1'b0, go = 1'b0, busReqPin, instrDone_ff, irqReq_n_ff, illegalInt_ff, halted_ff;
	logic [7:0] firstByte = 8'hA5, intStatus_ff;
	logic [2:0] phSel = 3'h0;
	logic [31:0] nextPtr = 32'h0, hostPtrData = 32'h0, instrPtr_ff, retAddr_ff, operandReg_ff;
	stc_instr_t instr = '0;
	stc_buslines_t busLinesPin;
	int nFail = 0, checksDone = 0, cyc = 0;
	always #25 clk_sys = ~clk_sys;
	stc_unit u_dut (.clk_sys, .rst, .clkEn(1'b1), .instrValid, .instr, .nextPtr, .aluCarry, .firstByte, .targetMode,
		.busLinesPin, .busReqPin, .busAtnPin, .hostPtrWrite, .hostPtrData, .hostIntAck(hostPtrWrite), .instrDone_ff,
		.instrPtr_ff, .retAddr_ff, .operandReg_ff, .intStatus_ff, .irqReq_n_ff, .illegalInt_ff, .halted_ff);
	stc_bus_model u_bus (.clk_sys, .rst, .go, .phSel, .busLinesPin, .busReqPin);
	task automatic giveVerdict;
		if (nFail == 0 && checksDone > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : giveVerdict
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 2000) begin
			nFail++;
			giveVerdict();
		end
	end
	function automatic logic [31:0] cw(input logic [2:0] op, input logic [7:0] f, input logic [2:0] ph = 3'h0,
		input logic [15:0] mv = 16'h0);
		return {2'b10, op, ph, f, mv};
	endfunction : cw
	// A refused instruction never answers, so ok=0 skips that check.
	task automatic run(input logic [31:0] c, o, n, input logic ok = 1'b1);
		int k = 0;
		@(posedge clk_sys);
		instr <= {c, o};
		nextPtr <= n;
		instrValid <= 1'b1;
		do begin
			@(posedge clk_sys);
			#1;
			k++;
		end while (instrDone_ff !== 1'b1 && k < 8);
		if (ok) `CK(instrDone_ff, 1'b1)
		@(posedge clk_sys);
		instrValid <= 1'b0;
	endtask : run
	task automatic host(input logic [31:0] a);
		@(posedge clk_sys);
		hostPtrWrite <= 1'b1;
		hostPtrData <= a;
		@(posedge clk_sys);
		hostPtrWrite <= 1'b0;
		#1;
	endtask : host
	task automatic tBranch;
		run(cw(3'h0, 8'h00), 32'h1000, 32'h108);
		`CK(instrPtr_ff, 32'h1000)
		run(cw(3'h0, 8'h28), 32'h2000, 32'h1008);
		`CK(instrPtr_ff, 32'h1008)
		run(cw(3'h0, 8'h20), 32'h2000, 32'h1010);
		`CK(instrPtr_ff, 32'h2000)
		run(cw(3'h1, 8'h00), 32'h3000, 32'h204);
		`CK(retAddr_ff, 32'h204)
		run(cw(3'h1, 8'h80), 32'hFFFFF0, 32'h3008);
		`CK(instrPtr_ff, 32'h2FF8)
		run(cw(3'h2, 8'h80), 32'h40, 32'h2FF8);
		`CK(instrPtr_ff, 32'h3008)
		run(cw(3'h0, 8'h0C, 3'h0, 16'h0FA0), 32'h4000, 32'h10);
		`CK(instrPtr_ff, 32'h4000)
		run(cw(3'h0, 8'h0C, 3'h0, 16'h00A0), 32'h5000, 32'h18);
		`CK(instrPtr_ff, 32'h18)
	endtask : tBranch
	task automatic tPhase;
		for (int p = 0; p < 8; p++) begin
			@(posedge clk_sys) phSel <= 3'(p);
			go <= 1'b1;
			@(posedge clk_sys) go <= 1'b0;
			repeat (12) @(posedge clk_sys);
			run(cw(3'h0, 8'h0A, 3'(p)), 32'h6000, 32'h100);
			`CK(instrPtr_ff, 32'h6000)
			run(cw(3'h0, 8'h0A, 3'(p + 1)), 32'h6000, 32'h108);
			`CK(instrPtr_ff, 32'h108)
		end
		run(cw(3'h0, 8'h0E, 3'h7, 16'h00A0), 32'h7000, 32'h200);
		`CK(instrPtr_ff, 32'h200)
		run(cw(3'h0, 8'h06, 3'h6, 16'h00A0), 32'h7000, 32'h208);
		`CK(instrPtr_ff, 32'h7000)
		run(cw(3'h0, 8'h0B, 3'h7), 32'h9000, 32'h500);
		`CK(instrPtr_ff, 32'h9000)
		run(cw(3'h0, 8'h0B, 3'h7), 32'hA000, 32'h508, 1'b0);
		`CK({instrDone_ff, instrPtr_ff}, {1'b0, 32'h9000})
		@(posedge clk_sys) go <= 1'b1;
		@(posedge clk_sys) go <= 1'b0;
		run(cw(3'h0, 8'h0B, 3'h7), 32'hA000, 32'h510);
		`CK(instrPtr_ff, 32'hA000)
		@(posedge clk_sys) targetMode <= 1'b1;
		busAtnPin <= 1'b1;
		repeat (3) @(posedge clk_sys);
		run(cw(3'h0, 8'h0A), 32'h8000, 32'h300);
		`CK(instrPtr_ff, 32'h8000)
		@(posedge clk_sys) targetMode <= 1'b0;
	endtask : tPhase
	task automatic tInt;
		run(cw(3'h3, 8'h10), 32'hABCD0001, 32'h400);
		`CK({intStatus_ff[FLY_STAT_BIT], halted_ff}, 2'b10)
		run(cw(3'h3, 8'h80), 32'h12345678, 32'h408);
		`CK({irqReq_n_ff, halted_ff, operandReg_ff}, {2'b01, 32'h12345678})
		run(cw(3'h0, 8'h00), 32'h9000, 32'h410, 1'b0);
		host(32'h700);
		`CK({irqReq_n_ff, halted_ff, instrPtr_ff}, {2'b10, 32'h700})
		for (int op = 4; op < 8; op++) begin
			run(cw(3'(op), 8'h00), 32'hA000, 32'h600, 1'b0);
			`CK({illegalInt_ff, irqReq_n_ff, halted_ff, instrPtr_ff}, {3'b101, 32'h700})
			host(32'h700);
		end
	endtask : tInt
	initial begin
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		tBranch();
		tPhase();
		tInt();
		giveVerdict();
	end
endmodule : tb_script_transfer_control_unit
`default_nettype wire
